// File: ect_pkg.sv
package ect_pkg;

  // ==========================================================
  // register map: word indices, byte address is four times index
  localparam logic [9:0] ECT_IDX_CTRL  = 10'h0bb;
  localparam logic [9:0] ECT_IDX_STAT  = 10'h0bc;
  localparam logic [9:0] ECT_IDX_FALL  = 10'h0bd;
  localparam logic [9:0] ECT_IDX_RISE  = 10'h0be;
  localparam logic [9:0] ECT_IDX_COUNT = 10'h0bf;

  // ==========================================================
  // field positions
  localparam int ECT_STAT_WRAP_BIT = 7;
  localparam int ECT_STAT_CAPT_BIT = 6;
  localparam int ECT_CTRL_EN_BIT   = 0;
  localparam int ECT_CTRL_SEL_LSB  = 1;

  // ==========================================================
  // reset values and counter limits
  localparam logic [7:0] ECT_COUNT_RST = 8'h00;
  localparam logic [7:0] ECT_COUNT_MAX = 8'hff;
  localparam logic [7:0] ECT_CAPT_RST  = 8'h00;
  localparam logic [7:0] ECT_CTRL_RST  = 8'h00;
  localparam logic [5:0] ECT_DIV_RST   = 6'h00;

  // tick divide ratios per select code: 1, 4, 16, 64 cycles
  localparam logic [5:0] ECT_DIV_SEL0 = 6'h00;
  localparam logic [5:0] ECT_DIV_SEL1 = 6'h03;
  localparam logic [5:0] ECT_DIV_SEL2 = 6'h0f;
  localparam logic [5:0] ECT_DIV_SEL3 = 6'h3f;

  // ==========================================================
  // wishbone carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ect_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ect_wb_rsp_t;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic [1:0]  capt_sync;
    logic        capt_prev;
    logic [7:0]  count;
    logic [5:0]  div;
    logic [7:0]  ctrl;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic        wrap_flag;
    logic        capt_flag;
    logic        wrap_armed;
    logic        capt_armed;
    logic        ack;
    logic [31:0] rdata;
  } ect_state_t;

endpackage : ect_pkg

// File: ect_top.sv
`timescale 1ns/1ns

// Function
// - set wrap flag when counter rolls ff to 00
// - flag clears only after read-one then write-zero
// - status bits 7,6 cleared by zero, one ignored
// - falling input edge copies counter to fall capture
// - rising input edge copies counter to rise capture
module ect_top
  import ect_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire ect_wb_req_t wb_req,
  output      ect_wb_rsp_t wb_rsp,
  input  wire logic        capture_in,
  output      logic [7:0]  capture_timer_count,
  output      logic        count_wrap_flag
);

  ect_state_t s_q;
  ect_state_t s_d;

  logic       bus_hit;
  logic       wr_en;
  logic       rd_en;
  logic       tick;
  logic [5:0] div_lim;
  logic       rise_ev;
  logic       fall_ev;
  logic       clr_wrap;
  logic       clr_capt;
  logic [9:0] idx;
  logic       hit_ctrl;
  logic       hit_stat;
  logic       hit_fall;
  logic       hit_rise;
  logic       hit_count;
  logic [31:0] rd_word;

  // word index; byte lanes below bit 2 are ignored
  assign idx     = wb_req.adr[11:2];
  // ack high gates the hit, so a held request is taken only every other cycle
  assign bus_hit = wb_req.cyc & wb_req.stb & ~s_q.ack;
  assign wr_en   = bus_hit & wb_req.we & wb_req.sel[0];
  assign rd_en   = bus_hit & ~wb_req.we;

  // ==========================================================
  // register decode
  assign hit_ctrl  = (idx == ECT_IDX_CTRL);
  assign hit_stat  = (idx == ECT_IDX_STAT);
  assign hit_fall  = (idx == ECT_IDX_FALL);
  assign hit_rise  = (idx == ECT_IDX_RISE);
  assign hit_count = (idx == ECT_IDX_COUNT);

  // ==========================================================
  // count tick divider
  always_comb
  begin
    case (s_q.ctrl[ECT_CTRL_SEL_LSB +: 2])
      2'd0:    div_lim = ECT_DIV_SEL0;
      2'd1:    div_lim = ECT_DIV_SEL1;
      2'd2:    div_lim = ECT_DIV_SEL2;
      default: div_lim = ECT_DIV_SEL3;
    endcase
  end

  // divider restarts while stopped, so the first tick comes a full ratio after enable
  assign tick = s_q.ctrl[ECT_CTRL_EN_BIT] & (s_q.div >= div_lim);

  // edges seen on the second sync stage only, never the first
  assign rise_ev = s_q.capt_sync[1] & ~s_q.capt_prev;
  assign fall_ev = ~s_q.capt_sync[1] & s_q.capt_prev;

  // clear needs a prior armed read
  assign clr_wrap = wr_en & (idx == ECT_IDX_STAT) & s_q.wrap_armed & ~wb_req.dat[ECT_STAT_WRAP_BIT];
  assign clr_capt = wr_en & (idx == ECT_IDX_STAT) & s_q.capt_armed & ~wb_req.dat[ECT_STAT_CAPT_BIT];

  // ==========================================================
  // next state
  always_comb
  begin
    s_d           = s_q;
    s_d.capt_sync = {s_q.capt_sync[0], capture_in};
    s_d.capt_prev = s_q.capt_sync[1];

    if (!s_q.ctrl[ECT_CTRL_EN_BIT] || tick)
    begin
      s_d.div = ECT_DIV_RST;
    end
    else
    begin
      s_d.div = s_q.div + 6'h01;
    end

    if (tick)
    begin
      s_d.count = s_q.count + 8'h01;
    end

    if (fall_ev)
    begin
      s_d.fall = s_q.count;
    end
    if (rise_ev)
    begin
      s_d.rise = s_q.count;
    end

    // the counter itself is not writable; only the control byte, all 8 bits with enable and tick select
    if (wr_en && idx == ECT_IDX_CTRL)
    begin
      s_d.ctrl = wb_req.dat[7:0];
    end

    // status write ends any armed read, whatever the written value
    if (wr_en && idx == ECT_IDX_STAT)
    begin
      s_d.wrap_armed = 1'b0;
      s_d.capt_armed = 1'b0;
    end
    // a read that sees zero leaves that flag unarmed
    // arm on a read that sees one
    if (rd_en && idx == ECT_IDX_STAT)
    begin
      s_d.wrap_armed = s_q.wrap_flag;
      s_d.capt_armed = s_q.capt_flag;
    end

    if (clr_wrap)
    begin
      s_d.wrap_flag = 1'b0;
    end
    if (clr_capt)
    begin
      s_d.capt_flag = 1'b0;
    end
    // set on wrap, set beats clear
    if (tick && s_q.count == ECT_COUNT_MAX)
    begin
      s_d.wrap_flag = 1'b1;
    end
    // capture flag: any edge, same set-wins order
    if (rise_ev || fall_ev)
    begin
      s_d.capt_flag = 1'b1;
    end

    // single-cycle ack, dropped the cycle after; data only stands with ack
    s_d.ack   = bus_hit;
    s_d.rdata = rd_en ? rd_word : 32'h0000_0000;
  end

  // ==========================================================
  // read data mux; unmapped words and upper bits read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl)
    begin
      rd_word[7:0] = s_q.ctrl;
    end
    if (hit_stat)
    begin
      rd_word[ECT_STAT_WRAP_BIT] = s_q.wrap_flag;
      rd_word[ECT_STAT_CAPT_BIT] = s_q.capt_flag;
    end
    if (hit_fall)
    begin
      rd_word[7:0] = s_q.fall;
    end
    if (hit_rise)
    begin
      rd_word[7:0] = s_q.rise;
    end
    if (hit_count)
    begin
      rd_word[7:0] = s_q.count;
    end
  end

  // ==========================================================
  // state register
  // reset loads constants only; a request may follow the first edge after release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.capt_sync  <= 2'b00;
      s_q.capt_prev  <= 1'b0;
      s_q.count      <= ECT_COUNT_RST;
      s_q.div        <= ECT_DIV_RST;
      s_q.ctrl       <= ECT_CTRL_RST;
      s_q.rise       <= ECT_CAPT_RST;
      s_q.fall       <= ECT_CAPT_RST;
      s_q.wrap_flag  <= 1'b0;
      s_q.capt_flag  <= 1'b0;
      s_q.wrap_armed <= 1'b0;
      s_q.capt_armed <= 1'b0;
      s_q.ack        <= 1'b0;
      s_q.rdata      <= 32'h0000_0000;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign wb_rsp.ack          = s_q.ack;
  assign wb_rsp.dat          = s_q.rdata;
  assign capture_timer_count = s_q.count;
  assign count_wrap_flag     = s_q.wrap_flag;

endmodule : ect_top

// File: ect_top_sva.sv
`timescale 1ns/1ns
// ====================
// bus and flag checks
module ect_top_sva
  import ect_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire ect_wb_req_t wb_req,
  input wire ect_wb_rsp_t wb_rsp,
  input wire logic        capture_in,
  input wire logic [7:0]  capture_timer_count,
  input wire logic        count_wrap_flag
);
  logic wr_stat;
  assign wr_stat = wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && !wb_rsp.ack
    && wb_req.adr == {ECT_IDX_STAT, 2'b00};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_wrap_sets:
    assert property ((capture_timer_count == 8'hff ##1 capture_timer_count == 8'h00) |-> count_wrap_flag)
      else $error("wrap flag missed");
  chk_flag_clear:
    assert property ($fell(count_wrap_flag) |-> $past(wr_stat && !wb_req.dat[7])) else $error("flag fell");
  chk_one_kept:
    assert property (wr_stat && wb_req.dat[7] && count_wrap_flag |=> count_wrap_flag) else $error("one cleared");
  chk_count_step:
    assert property ($changed(capture_timer_count) |-> capture_timer_count == $past(capture_timer_count) + 8'h01)
      else $error("count jump");
  chk_ack_pulse:
    assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held");
  chk_ack_latency:
    assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack) else $error("ack late");
  chk_read_upper:
    assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0) else $error("upper bits set");
  cover property ($rose(count_wrap_flag));
  cover property (wr_stat && !wb_req.dat[7] && count_wrap_flag);
  cover property ($fell(capture_in));
endmodule : ect_top_sva

bind ect_top ect_top_sva ect_top_sva_inst (.clk(clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .capture_in(capture_in), .capture_timer_count(capture_timer_count), .count_wrap_flag(count_wrap_flag));

// File: ect_pin_src.sv
`timescale 1ns/1ns
// ====================
// capture pin source, prompt or five cycles slow
module ect_pin_src
(
  input  wire logic clk,
  input  wire logic lvl,
  input  wire logic slow,
  output      logic pin
);
  logic [2:0] dly_q = 3'h0;
  initial pin = 1'b0;
  always @(posedge clk)
    if (pin == lvl)
      dly_q <= slow ? 3'h5 : 3'h0;
    else if (dly_q != 3'h0)
      dly_q <= dly_q - 3'h1;
    else
      pin <= lvl;
endmodule : ect_pin_src

// File: edge_capture_timer_test.sv
`timescale 1ns/1ns
// ====================
// stimulus and checks
module edge_capture_timer_test;
  import ect_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        lvl = 1'b0;
  logic        slow = 1'b0;
  logic        pin;
  logic [7:0]  cnt;
  logic        flag;
  logic [7:0]  r;
  logic [7:0]  c;
  ect_wb_req_t req = '0;
  ect_wb_rsp_t rsp;
  int          mismatches = 0;
  int          checks = 0;
  int          seed = 13776;
  int          i;
  int          cyc_n = 0;
  int          t_ack = 0;
  int          t_on = 0;
  always #20 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;
  ect_top ect_top_inst (.clk(clk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp), .capture_in(pin),
    .capture_timer_count(cnt), .count_wrap_flag(flag));
  ect_pin_src ect_pin_src_inst (.clk(clk), .lvl(lvl), .slow(slow), .pin(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  // counter after so many enabled edges, divider starting from zero
  function automatic logic [7:0] next_count(input logic [7:0] base, input int edges, input logic [1:0] sel);
    int ratio;
    case (sel)
      2'd0:    ratio = int'(ECT_DIV_SEL0) + 1;
      2'd1:    ratio = int'(ECT_DIV_SEL1) + 1;
      2'd2:    ratio = int'(ECT_DIV_SEL2) + 1;
      default: ratio = int'(ECT_DIV_SEL3) + 1;
    endcase
    return base + 8'(edges / ratio);
  endfunction : next_count
  task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, wd}};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.ack !== 1'b1 && n < 50);
    rd = rsp.dat[7:0];
    t_ack = cyc_n;
    req <= '0;
    @(posedge clk);
    if (n >= 50)
      mismatches++;
  endtask : wb
  task automatic final_report();
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 6; i++)
    begin
      wb(1'b0, 10'h0ba + 10'(i), 8'h00, r);
      chk(r, 8'h00);
    end
    wb(1'b1, ECT_IDX_CTRL, 8'h01, r);
    t_on = t_ack;
    c = ECT_COUNT_RST;
    for (i = 0; i < 300 && flag !== 1'b1; i++)
      @(posedge clk);
    chk(flag, 1'b1);
    // zero without prior read must not clear
    wb(1'b1, ECT_IDX_STAT, 8'h00, r);
    chk(flag, 1'b1);
    wb(1'b0, ECT_IDX_STAT, 8'h00, r);
    chk(r & 8'h80, 8'h80);
    wb(1'b1, ECT_IDX_STAT, 8'hc0, r);
    chk(flag, 1'b1);
    wb(1'b0, ECT_IDX_STAT, 8'h00, r);
    wb(1'b1, ECT_IDX_STAT, 8'h00, r);
    chk(flag, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      wb(1'b1, ECT_IDX_CTRL, {5'h0, i[1:0], 1'b1}, r);
      if (i > 0)
        t_on = t_ack;
      repeat ({$random(seed)} % 40 + 1) @(posedge clk);
      wb(1'b1, ECT_IDX_CTRL, 8'h00, r);
      c = next_count(c, t_ack - t_on, i[1:0]);
      wb(1'b0, ECT_IDX_COUNT, 8'h00, r);
      chk(r, c);
      slow <= 1'($random(seed));
      lvl <= ~lvl;
      repeat (16) @(posedge clk);
      wb(1'b1, lvl ? ECT_IDX_RISE : ECT_IDX_FALL, 8'($random(seed)), r);
      wb(1'b0, lvl ? ECT_IDX_RISE : ECT_IDX_FALL, 8'h00, r);
      chk(r, c);
    end
    // capture flag: a written one is ignored, a zero after an armed read clears
    wb(1'b0, ECT_IDX_STAT, 8'h00, r);
    chk(r & 8'h40, 8'h40);
    wb(1'b1, ECT_IDX_STAT, 8'hc0, r);
    wb(1'b0, ECT_IDX_STAT, 8'h00, r);
    chk(r & 8'h40, 8'h40);
    wb(1'b1, ECT_IDX_STAT, 8'h80, r);
    wb(1'b0, ECT_IDX_STAT, 8'h00, r);
    chk(r & 8'h40, 8'h00);
    final_report();
  end
  initial
  begin
    #2000000;
    mismatches++;
    final_report();
  end
endmodule : edge_capture_timer_test
